// [sids_peer.sv]
// serial link partner: clock, select and data toward the port
`timescale 1ns/1ps
module sids_peer (
   output logic      link_clk_out, // serial clock, still low between frames
   output logic      select_b_out, // chip select, active low
   output logic      data_out,     // serial data toward the port
   input  wire logic data_in       // serial data from the port
);
   // idle link: clock low, select released
   initial begin
      link_clk_out = 1'b0;
      select_b_out = 1'b1;
      data_out = 1'b1;
   end
   // one frame of n bits, msb first; sel frames it by select
   task automatic frame(input logic [15:0] tx, input int n, input logic sel, output logic [15:0] rx);
      rx = 16'h0000;
      select_b_out = !sel;
      #800;
      for (int i = n - 1; i >= 0; i--) begin
         data_out = tx[i];                // set up well ahead of the rise
         #200 link_clk_out = 1'b1;        // 800 ns period, 400 ns high
         #400 link_clk_out = 1'b0;
         #200 rx = {rx[14:0], data_in};  // port moves its bit 300 to 400 ns after a fall
      end
      #400 select_b_out = 1'b1;
      data_out = ~data_out;  // released line shows no stale bit
   endtask
endmodule // sids_peer

// [sids_pkg.sv]
// constants shared by the serial port register block: offsets, bit positions, reset values
package sids_pkg;
   // register byte offsets on the peripheral bus
   localparam logic [7:0]  OFF_PORT_CFG    = 8'h00;  // main control: port on, master, width, mode
   localparam logic [7:0]  OFF_AUX_CTRL    = 8'h04;  // interrupt, dma and select-drive enables
   localparam logic [7:0]  OFF_FLAG_STATUS = 8'h08;  // status flags
   localparam logic [7:0]  OFF_DATA_PORT   = 8'h0C;  // send buffer on write, receive buffer on read
   localparam logic [7:0]  OFF_RX_CHECK    = 8'h14;  // expected received check value
   // main control fields
   localparam int          CFG_MASTER      = 2;      // master role
   localparam int          CFG_PORT_ON     = 6;      // port enable
   localparam int          CFG_FRAME_WIDTH = 11;     // 0: 8-bit frames, 1: 16-bit frames
   localparam int          CFG_AUDIO_MODE  = 12;     // 0: spi, 1: audio serial
   localparam int          CFG_CHECK_NEXT  = 13;     // next received frame is the check value
   localparam logic [15:0] CFG_WR_MASK     = 16'h3844;
   // auxiliary control fields
   localparam int          AUX_TX_EMPTY_IRQ_EN = 7;
   localparam int          AUX_RX_AVAIL_IRQ_EN = 6;
   localparam int          AUX_FAULT_IRQ_EN    = 5;
   localparam int          AUX_SELECT_OUT      = 2;
   localparam int          AUX_TX_DMA_REQ_EN   = 1;
   localparam int          AUX_RX_DMA_REQ_EN   = 0;
   localparam logic [15:0] AUX_WR_MASK         = 16'h00E7;
   // status fields
   localparam int          STS_BUSY        = 7;
   localparam int          STS_OVERRUN     = 6;
   localparam int          STS_CONFLICT    = 5;
   localparam int          STS_CHECK_MIS   = 4;
   localparam int          STS_UNDERRUN    = 3;
   localparam int          STS_AUDIO_SIDE  = 2;
   localparam int          STS_TX_EMPTY    = 1;
   localparam int          STS_RX_AVAIL    = 0;
   // reset values and frame lengths
   localparam logic [15:0] CFG_RST         = 16'h0000;
   localparam logic [15:0] AUX_RST         = 16'h0000;
   localparam logic [15:0] STATUS_RST      = 16'h0002;
   localparam logic [15:0] DATA_RST        = 16'h0000;
   localparam logic [15:0] CHECK_RST       = 16'h0000;
   localparam logic [4:0]  BITS_NARROW     = 5'h08;  // bits in an 8-bit frame
   localparam logic [4:0]  BITS_WIDE       = 5'h10;  // bits in a 16-bit frame
   // link engine states
   typedef enum logic [1:0] {
      LINK_IDLE  = 2'b01,
      LINK_SHIFT = 2'b10
   } sids_link_e;
endpackage

// [sids_top.sv]
// serial port register block: control, status, data buffers and a minimal link shifter
`timescale 1ns/1ps

// Summary of operation
// - send-empty enable requests interrupt while empty
// - receive enable requests interrupt while data waits
// - fault enable requests interrupt on any error
// - select drive on: port-on spi master drives chip select pin
// - transmit dma request when send empty
// - receive dma request when receive holds data
// - busy set by hardware while shifting or pending
// - overrun set by hardware, cleared by sequence
// - mode conflict sticky until clearing sequence
// - check mismatch set, cleared writing zero
// - underrun in audio mode, sequence clears
// - audio side flag: left zero, right one
// - send empty flag, resets to empty
// - receive available flag shows unread word
// - one address, separate send and receive buffers
// - 8-bit frames use low byte, upper zero
// - 16-bit frames use all sixteen bits
// - width select: 0 eight bits, 1 sixteen
module sids_top (
   input  wire logic        mclk_in,          // bus clock, 10 MHz
   input  wire logic        rst_b_in,         // synchronous reset, active low
   input  wire logic        psel_in,          // apb select
   input  wire logic        penable_in,       // apb access phase
   input  wire logic        pwrite_in,        // apb direction
   input  wire logic [7:0]  paddr_in,         // apb byte address
   input  wire logic [31:0] pwdata_in,        // apb write data
   output logic      [31:0] prdata_out,       // apb read data
   output logic             pready_out,       // apb ready
   output logic             pslverr_out,      // apb error on unmapped address
   input  wire logic        link_clk_in,      // serial clock from the partner
   input  wire logic        link_din_in,      // serial data in
   output logic             link_dout_out,    // serial data out
   input  wire logic        chip_select_pin_in,      // chip select pin level
   output logic             chip_select_pin_out,     // chip select drive level
   output logic             chip_select_pin_oe_b_out, // low while driving the pin
   output logic             irq_out,          // combined interrupt request
   output logic             tx_dma_req_out,   // transmit dma request
   output logic             rx_dma_req_out    // receive dma request
);
   // register state
   logic [15:0] cfg_q;                  // main control
   logic [15:0] aux_q;                  // auxiliary control
   logic [15:0] rx_check_q;             // expected check value
   logic [15:0] tx_buf_q;               // send buffer
   logic [15:0] rx_buf_q;               // receive buffer
   logic        tx_empty_q;             // send buffer empty
   logic        rx_avail_q;             // receive buffer holds a word
   logic        overrun_q;              // overflow error
   logic        conflict_q;             // master conflict error
   logic        check_mis_q;            // check value mismatch
   logic        underrun_q;             // audio underflow
   logic        side_q;                 // audio channel due
   logic        armed_q;                // last completed access was a status read
   // link state
   sids_pkg::sids_link_e state_q;       // link engine state
   logic [15:0] tx_sh_q;                // outgoing shift register
   logic [15:0] rx_sh_q;                // incoming shift register
   logic [4:0]  bit_cnt_q;              // bits taken in this frame
   logic        sck_s1_q, sck_s2_q, sck_s3_q;   // link clock synchroniser and history
   logic        din_s1_q, din_s2_q;     // data synchroniser
   logic        cs_s1_q, cs_s2_q;       // chip select synchroniser

   // bus decode
   wire         setup     = psel_in & ~penable_in;
   wire         done      = psel_in & penable_in & pready_out;
   wire         wr_done   = done & pwrite_in;
   wire         rd_done   = done & ~pwrite_in;
   wire         hit_cfg   = paddr_in == sids_pkg::OFF_PORT_CFG;
   wire         hit_aux   = paddr_in == sids_pkg::OFF_AUX_CTRL;
   wire         hit_sts   = paddr_in == sids_pkg::OFF_FLAG_STATUS;
   wire         hit_dat   = paddr_in == sids_pkg::OFF_DATA_PORT;
   wire         hit_chk   = paddr_in == sids_pkg::OFF_RX_CHECK;
   wire         mapped    = hit_cfg | hit_aux | hit_sts | hit_dat | hit_chk;
   wire         wr_cfg    = wr_done & hit_cfg;
   wire         wr_sts    = wr_done & hit_sts;
   wire         wr_dat    = wr_done & hit_dat;
   wire         rd_sts    = rd_done & hit_sts;
   wire         rd_dat    = rd_done & hit_dat;

   // mode decode
   wire         port_on   = cfg_q[sids_pkg::CFG_PORT_ON];
   wire         audio     = cfg_q[sids_pkg::CFG_AUDIO_MODE];
   wire         wide      = cfg_q[sids_pkg::CFG_FRAME_WIDTH];
   wire [4:0]   frame_len = wide ? sids_pkg::BITS_WIDE : sids_pkg::BITS_NARROW;
   wire [15:0]  width_mask = wide ? 16'hFFFF : 16'h00FF;

   // link edge and frame decode
   wire         sck_rise  = sck_s2_q & ~sck_s3_q;
   wire         sck_fall  = ~sck_s2_q & sck_s3_q;
   wire         drive_cs  = port_on & cfg_q[sids_pkg::CFG_MASTER] & aux_q[sids_pkg::AUX_SELECT_OUT] & ~audio;
   wire         frame_on  = audio ? port_on : (port_on & ~cs_s2_q);
   wire         start     = (state_q == sids_pkg::LINK_IDLE) & frame_on & sck_rise;
   wire         shifting  = (state_q == sids_pkg::LINK_SHIFT);
   wire [4:0]   cnt_next  = 5'(bit_cnt_q + 5'h01);
   wire         last_bit  = shifting & frame_on & sck_rise & (cnt_next == frame_len);
   wire [15:0]  rx_word   = {rx_sh_q[14:0], din_s2_q} & width_mask;
   wire         check_frm = last_bit & cfg_q[sids_pkg::CFG_CHECK_NEXT] & ~audio;
   wire         data_frm  = last_bit & ~check_frm;
   wire         busy      = shifting | ~tx_empty_q;

   // flag events
   wire         tx_load   = start;
   wire         ovr_set   = data_frm & rx_avail_q & ~rd_dat;
   wire         rx_store  = data_frm & ~ovr_set;
   wire         unr_set   = start & tx_empty_q & audio;
   wire         conf_set  = port_on & cfg_q[sids_pkg::CFG_MASTER] & ~audio & ~drive_cs & ~cs_s2_q;
   wire         chk_set   = check_frm & (rx_word != (rx_check_q & width_mask));
   wire [15:0]  status_w  = {8'h00, busy, overrun_q, conflict_q, check_mis_q, underrun_q, side_q, tx_empty_q,
                             rx_avail_q};
   wire         fault     = overrun_q | conflict_q | check_mis_q | underrun_q;
   wire         irq_d     = (aux_q[sids_pkg::AUX_TX_EMPTY_IRQ_EN] & tx_empty_q)
                          | (aux_q[sids_pkg::AUX_RX_AVAIL_IRQ_EN] & rx_avail_q)
                          | (aux_q[sids_pkg::AUX_FAULT_IRQ_EN] & fault);

   // read data selection
   wire [15:0]  rd_word   = hit_cfg ? cfg_q :
                            hit_aux ? aux_q :
                            hit_sts ? status_w :
                            hit_dat ? rx_buf_q :
                            hit_chk ? rx_check_q : 16'h0000;

   // pin synchronisers, two flops before any use
   always_ff @(posedge mclk_in) begin
      sck_s1_q <= link_clk_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      din_s1_q <= link_din_in;
      din_s2_q <= din_s1_q;
      cs_s1_q  <= chip_select_pin_in;
      cs_s2_q  <= cs_s1_q;
   end

   // apb answer: data captured in setup, ready in the first access cycle
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out  <= setup;
         pslverr_out <= setup & ~mapped;
         if (setup) begin
            prdata_out <= {16'h0000, rd_word};
         end
      end
   end

   // main control; width may only change while the port is off
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         cfg_q <= sids_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_q <= pwdata_in[15:0] & sids_pkg::CFG_WR_MASK;
         if (port_on) begin
            cfg_q[sids_pkg::CFG_FRAME_WIDTH] <= cfg_q[sids_pkg::CFG_FRAME_WIDTH];
         end
      end else if (check_frm) begin
         cfg_q[sids_pkg::CFG_CHECK_NEXT] <= 1'b0;         // check frame consumed
      end
   end

   // auxiliary control and expected check value
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         aux_q      <= sids_pkg::AUX_RST;
         rx_check_q <= sids_pkg::CHECK_RST;
      end else begin
         if (wr_done & hit_aux) begin
            aux_q <= pwdata_in[15:0] & sids_pkg::AUX_WR_MASK;
         end
         if (wr_done & hit_chk) begin
            rx_check_q <= pwdata_in[15:0];
         end
      end
   end

   // send buffer; a write in the load cycle keeps the buffer full
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         tx_buf_q   <= sids_pkg::DATA_RST;
         tx_empty_q <= sids_pkg::STATUS_RST[sids_pkg::STS_TX_EMPTY];
      end else if (wr_dat) begin
         tx_buf_q   <= pwdata_in[15:0] & width_mask;
         tx_empty_q <= 1'b0;
      end else if (tx_load) begin
         tx_empty_q <= 1'b1;
      end
   end

   // receive buffer; a new word wins over a read in the same cycle
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         rx_buf_q   <= sids_pkg::DATA_RST;
         rx_avail_q <= sids_pkg::STATUS_RST[sids_pkg::STS_RX_AVAIL];
      end else if (rx_store) begin
         rx_buf_q   <= rx_word;
         rx_avail_q <= 1'b1;
      end else if (rd_dat) begin
         rx_avail_q <= 1'b0;
      end
   end

   // sequence tracker: armed by a status read, dropped by any other access
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         armed_q <= 1'b0;
      end else if (done) begin
         armed_q <= rd_sts;
      end
   end

   // error flags: hardware set wins over the software clear
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         overrun_q   <= sids_pkg::STATUS_RST[sids_pkg::STS_OVERRUN];
         conflict_q  <= sids_pkg::STATUS_RST[sids_pkg::STS_CONFLICT];
         check_mis_q <= sids_pkg::STATUS_RST[sids_pkg::STS_CHECK_MIS];
         underrun_q  <= sids_pkg::STATUS_RST[sids_pkg::STS_UNDERRUN];
      end else begin
         overrun_q   <= ovr_set | (overrun_q & ~(rd_dat & armed_q));
         conflict_q  <= conf_set | (conflict_q & ~(wr_cfg & armed_q));
         check_mis_q <= chk_set | (check_mis_q & ~(wr_sts & ~pwdata_in[sids_pkg::STS_CHECK_MIS]));
         underrun_q  <= unr_set | (underrun_q & ~(wr_dat & armed_q));
      end
   end

   // link engine: load on first rising edge, sample on rising, shift out on falling
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         state_q   <= sids_pkg::LINK_IDLE;
         tx_sh_q   <= 16'h0000;
         rx_sh_q   <= 16'h0000;
         bit_cnt_q <= 5'h00;
         side_q    <= 1'b0;
      end else if (start) begin
         state_q   <= sids_pkg::LINK_SHIFT;
         tx_sh_q   <= tx_empty_q ? 16'h0000 : tx_buf_q;   // empty buffer sends zeros
         rx_sh_q   <= {15'h0000, din_s2_q};
         bit_cnt_q <= 5'h01;
      end else if (shifting & ~frame_on) begin
         state_q   <= sids_pkg::LINK_IDLE;                // frame aborted by select release or port off
         bit_cnt_q <= 5'h00;
      end else if (last_bit) begin
         state_q   <= sids_pkg::LINK_IDLE;
         bit_cnt_q <= 5'h00;
         side_q    <= audio & ~side_q;
      end else if (shifting & sck_rise) begin
         rx_sh_q   <= {rx_sh_q[14:0], din_s2_q};
         bit_cnt_q <= cnt_next;
      end else if (shifting & sck_fall) begin
         tx_sh_q   <= {tx_sh_q[14:0], 1'b0};
      end
   end

   // pins and request outputs, all registered
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         link_dout_out            <= 1'b0;
         chip_select_pin_out      <= 1'b1;
         chip_select_pin_oe_b_out <= 1'b1;
         irq_out                  <= 1'b0;
         tx_dma_req_out           <= 1'b0;
         rx_dma_req_out           <= 1'b0;
      end else begin
         link_dout_out            <= wide ? tx_sh_q[15] : tx_sh_q[7];
         chip_select_pin_out      <= ~drive_cs;
         chip_select_pin_oe_b_out <= ~drive_cs;
         irq_out                  <= irq_d;
         tx_dma_req_out           <= aux_q[sids_pkg::AUX_TX_DMA_REQ_EN] & tx_empty_q;
         rx_dma_req_out           <= aux_q[sids_pkg::AUX_RX_DMA_REQ_EN] & rx_avail_q;
      end
   end

endmodule // sids_top

// [sids_top_asserts.sv]
// port-level checker of the serial port register block
`timescale 1ns/1ps
module sids_top_asserts (
   input  wire logic        mclk_in,                  // bus clock
   input  wire logic        rst_b_in,                 // synchronous reset, active low
   input  wire logic        psel_in,                  // apb select
   input  wire logic        penable_in,               // apb access phase
   input  wire logic        pwrite_in,                // apb direction
   input  wire logic [7:0]  paddr_in,                 // apb address
   input  wire logic [31:0] pwdata_in,                // apb write data
   input  wire logic [31:0] prdata_out,               // apb read data
   input  wire logic        pready_out,               // apb ready
   input  wire logic        pslverr_out,              // apb error
   input  wire logic        chip_select_pin_out,      // select drive level
   input  wire logic        chip_select_pin_oe_b_out, // low while driving
   input  wire logic        irq_out,                  // combined interrupt
   input  wire logic        tx_dma_req_out,           // transmit request
   input  wire logic        rx_dma_req_out            // receive request
);
   logic [15:0] aux_m_q;  // mirror of the enables as software wrote them
   logic        done_w;   // a write completes at this edge
   logic        wr_aux;   // completed write to the enables
   logic        wr_dat;   // completed write to the send buffer
   assign done_w = psel_in && penable_in && pready_out && pwrite_in;
   assign wr_aux = done_w && (paddr_in == sids_pkg::OFF_AUX_CTRL);
   assign wr_dat = done_w && (paddr_in == sids_pkg::OFF_DATA_PORT);
   // follow the enables so request outputs can be tied to them
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         aux_m_q <= sids_pkg::AUX_RST;
      end else if (wr_aux) begin
         aux_m_q <= pwdata_in[15:0] & sids_pkg::AUX_WR_MASK;
      end
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   a_ready_one_cycle: assert property (pready_out |=> !pready_out) else $error("ready held too long");
   a_setup_gets_ready: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready after setup");
   a_ready_in_access: assert property (pready_out |-> psel_in && penable_in) else $error("ready outside access");
   a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("error without ready");
   a_rdata_upper_zero: assert property (pready_out |-> prdata_out[31:16] == 16'h0000) else $error("upper read bits set");
   a_select_drive_low: assert property (!chip_select_pin_oe_b_out |-> !chip_select_pin_out && $past(aux_m_q[2]))
      else $error("select driven without enable");
   a_tx_dma_gate: assert property (tx_dma_req_out |-> $past(aux_m_q[1])) else $error("tx request masked");
   a_rx_dma_gate: assert property (rx_dma_req_out |-> $past(aux_m_q[0])) else $error("rx request masked");
   a_irq_gate: assert property (irq_out |-> $past(aux_m_q[7:5]) != 3'b000) else $error("irq with no enable");
   a_data_wr_drops: assert property (wr_dat |-> ##2 !tx_dma_req_out) else $error("tx request after load");
endmodule // sids_top_asserts

// [sids_top_bench.sv]
// self-checking bench of the serial port register block
`timescale 1ns/1ps
module sids_top_bench;
   logic        mclk, rst_b, psel, penable, pwrite; // clock, reset, apb controls
   logic [7:0]  paddr;                              // apb address
   logic [31:0] pwdata, prdata, rd, seed;           // apb data, last read, seed
   logic        pready, pslverr, err;               // apb answer
   logic        lclk, ldin, ldout, sel_b;           // serial link
   logic        cs_drv, cs_oe_b, cs_pin;            // chip select pieces
   logic        irq, tx_req, rx_req;                // request outputs
   logic [15:0] got, w;                             // partner capture, word sent
   logic [15:0] rxq[$];                             // model of receive buffer contents
   int          miscompares, samples_checked, cycles;
   always #50 mclk = ~mclk;
   assign cs_pin = cs_oe_b ? sel_b : cs_drv;  // pin level from both parties
   sids_top dut (.mclk_in(mclk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .link_clk_in(lclk), .link_din_in(ldin), .link_dout_out(ldout), .chip_select_pin_in(cs_pin),
      .chip_select_pin_out(cs_drv), .chip_select_pin_oe_b_out(cs_oe_b), .irq_out(irq),
      .tx_dma_req_out(tx_req), .rx_dma_req_out(rx_req));
   sids_peer peer (.link_clk_out(lclk), .select_b_out(sel_b), .data_out(ldin), .data_in(ldout));
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 16'h0000);
      chk(rd, exp);
   endtask
   // let registered outputs land, then look off the edge
   task automatic settle;
      repeat (2) @(posedge mclk);
   endtask
   // one frame: optional load of the send buffer, random word from the partner
   task automatic xfer(input int n, input logic sel, input logic load);
      logic [15:0] din;
      din = 16'($random(seed));
      if (load) begin
         w = 16'($random(seed));
         apb(1'b1, sids_pkg::OFF_DATA_PORT, w);
         rchk(sids_pkg::OFF_FLAG_STATUS, 32'h00000080);
      end
      peer.frame(din, n, sel, got);
      if (load) chk({16'h0000, got}, n == 8 ? {24'h000000, w[7:0]} : {16'h0000, w});
      rxq.push_back(n == 8 ? {8'h00, din[7:0]} : din);
      @(posedge mclk);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test;
      end
   end
   // main sequence
   initial begin
      {mclk, rst_b, psel, penable, pwrite} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      seed = 32'h3731AFDB;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rchk(sids_pkg::OFF_FLAG_STATUS, 32'h00000002);
      rchk(sids_pkg::OFF_AUX_CTRL, 32'h00000000);
      apb(1'b0, 8'h30, 16'h0000);
      chk({31'h0, err}, 32'h00000001);
      w = 16'($random(seed));
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, w & sids_pkg::AUX_WR_MASK);
      rchk(sids_pkg::OFF_AUX_CTRL, {16'h0000, w & sids_pkg::AUX_WR_MASK});
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0082);
      settle;
      chk({29'h0, irq, tx_req, rx_req}, 32'h00000006);
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0061);
      settle;
      chk({29'h0, irq, tx_req, rx_req}, 32'h00000000);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0040);
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0043);
      xfer(8, 1'b1, 1'b1);
      rchk(sids_pkg::OFF_FLAG_STATUS, 32'h00000003);
      chk({29'h0, irq, tx_req, rx_req}, 32'h00000007);
      rchk(sids_pkg::OFF_DATA_PORT, {16'h0000, rxq.pop_front()});
      xfer(8, 1'b1, 1'b0);
      xfer(8, 1'b1, 1'b0);
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0020);
      settle;
      chk({29'h0, irq, tx_req, rx_req}, 32'h00000004);
      rchk(sids_pkg::OFF_FLAG_STATUS, 32'h00000043);
      rchk(sids_pkg::OFF_DATA_PORT, {16'h0000, rxq.pop_front()});
      rxq.delete();
      rchk(sids_pkg::OFF_FLAG_STATUS, 32'h00000002);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0000);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0800);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0840);
      xfer(16, 1'b1, 1'b1);
      rchk(sids_pkg::OFF_DATA_PORT, {16'h0000, rxq.pop_front()});
      apb(1'b1, sids_pkg::OFF_RX_CHECK, w);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h2840);
      xfer(16, 1'b1, 1'b0);
      apb(1'b0, sids_pkg::OFF_FLAG_STATUS, 16'h0000);
      chk(rd & 32'h00000010, 32'h00000010);
      apb(1'b1, sids_pkg::OFF_FLAG_STATUS, 16'h0000);
      apb(1'b0, sids_pkg::OFF_FLAG_STATUS, 16'h0000);
      chk(rd & 32'h00000010, 32'h00000000);
      apb(1'b0, sids_pkg::OFF_DATA_PORT, 16'h0000);
      rxq.delete();
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0000);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0844);
      peer.frame(16'h0000, 0, 1'b1, got);
      @(posedge mclk);
      apb(1'b0, sids_pkg::OFF_FLAG_STATUS, 16'h0000);
      chk(rd & 32'h00000020, 32'h00000020);
      chk({31'h0, cs_oe_b}, 32'h00000001);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0844);
      apb(1'b0, sids_pkg::OFF_FLAG_STATUS, 16'h0000);
      chk(rd & 32'h00000020, 32'h00000000);
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0004);
      settle;
      chk({30'h0, cs_oe_b, cs_pin}, 32'h00000000);
      apb(1'b1, sids_pkg::OFF_AUX_CTRL, 16'h0000);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h0000);
      apb(1'b1, sids_pkg::OFF_PORT_CFG, 16'h1840);
      xfer(16, 1'b0, 1'b0);
      apb(1'b0, sids_pkg::OFF_FLAG_STATUS, 16'h0000);
      chk(rd & 32'h0000000C, 32'h0000000C);
      finish_test;
   end
endmodule // sids_top_bench

bind sids_top sids_top_asserts chk_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .chip_select_pin_out(chip_select_pin_out), .chip_select_pin_oe_b_out(chip_select_pin_oe_b_out),
   .irq_out(irq_out), .tx_dma_req_out(tx_dma_req_out), .rx_dma_req_out(rx_dma_req_out));
